// ---- verilog/pdsr_readout.sv ----
// How it works
// - Self test ends by restoring every configuration setting to default.
// - Self test is slow; controller waits before further accesses.
// - Result readable as high byte alone or high then low.
// - After self test the result word holds a fixed signature.
// - Dump: high byte is address, low has value and status flag.
// - Enabling the dump loads the first pixel address with the status flag set invalid.
// - Status flag high means invalid, low means valid sample.
// - Pixel address and data advance on the following frame.
// - Pixel values span 0 black to 63 white.
// - Gain control adjusts exposure per frame to keep brightest pixel mid fifties.
// - Exposure value counts clock cycles and defaults to 64.
// - Exposure changes at most one sixteenth per frame.
// - Exposure never exceeds frame cycles minus 2816.
// - Self test bit runs tests, loads signature, reads as zero.
// - Sleep zero: sleep after one second idle; one: stay awake.
`timescale 1ns/1ps
module pdsr_readout #(
  parameter int FRAME_CYCLES = pdsr_pkg::CLK_HZ / pdsr_pkg::FRAME_RATE,
  parameter int SELF_TEST_CYCLES =
    pdsr_pkg::SELF_TEST_US * pdsr_pkg::CLK_MHZ,
  parameter int SLEEP_CYCLES = pdsr_pkg::SLEEP_S * pdsr_pkg::CLK_HZ,
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Two-wire serial port
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // Pixel stream from the array, same clock
  input wire logic pix_valid,
  input wire logic [pdsr_pkg::PIX_W-1:0] pix_value,
  output logic pix_ready,
  // Frame statistics, same clock
  input wire logic [pdsr_pkg::PIX_W-1:0] frame_max_pixel,
  input wire logic [pdsr_pkg::PIX_W-1:0] frame_avg_pixel,
  input wire logic motion,
  // Status
  output logic asleep,
  output logic led_on,
  output logic res_800,
  output logic self_test_busy
);
  localparam int FW = $clog2(FRAME_CYCLES + 1);
  localparam int SW = $clog2(SLEEP_CYCLES + 1);
  localparam int TW = $clog2(SELF_TEST_CYCLES + 1);
  localparam int IW = $clog2(pdsr_pkg::IDLE_TIMEOUT_CYC + 1);
  localparam logic [15:0] EXPO_MAX =
    16'(FRAME_CYCLES - pdsr_pkg::SHUTTER_OVERHEAD);

  if (FRAME_CYCLES - pdsr_pkg::SHUTTER_OVERHEAD <= 64 ||
      FRAME_CYCLES - pdsr_pkg::SHUTTER_OVERHEAD > 65535) begin : g_bad_frame
    $error("pdsr_readout frame length cannot hold the exposure range");
  end
  if (SELF_TEST_CYCLES < 2 || SLEEP_CYCLES < 2) begin : g_bad_counts
    $error("pdsr_readout counts must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial edge detection

  logic [2:0] sclk_sync_reg;
  logic [1:0] sdio_sync_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi;

  // Stage 0 feeds only stage 1; edges come from stages 1 and 2
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_sync_reg <= 3'h7; // Idle high: no false rise after reset
      sdio_sync_reg <= 2'h0;
    end else if (ce) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
    end
  end

  assign sclk_rise = ce & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ce & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign sdi = sdio_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Serial transaction engine

  pdsr_pkg::pdsr_ser_t ser_state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [6:0] addr_reg;
  logic [7:0] tx_reg;
  logic load_pend_reg;
  logic [IW-1:0] idle_cnt_reg;
  logic idle_out;
  logic rd_load;
  logic wr_now;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  assign idle_out = idle_cnt_reg == IW'(pdsr_pkg::IDLE_TIMEOUT_CYC - 1);
  assign rd_load = ce & load_pend_reg;
  assign wr_now = sclk_rise & (ser_state_reg == pdsr_pkg::SER_WDATA) &
                  (bit_cnt_reg == 3'h7);
  assign wr_data = {shift_reg[6:0], sdi};

  // A stalled port falls back to waiting for an address byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idle_cnt_reg <= '0;
    end else if (ce) begin
      if (sclk_rise || sclk_fall || idle_out) begin
        idle_cnt_reg <= '0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + IW'(1);
      end
    end
  end

  // Address byte, then eight data bits in or out, MSB first
  always_ff @(posedge clk) begin
    if (!resetn || (ce && idle_out)) begin
      ser_state_reg <= pdsr_pkg::SER_ADDR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      addr_reg <= 7'h00;
      load_pend_reg <= 1'b0;
    end else if (sclk_rise) begin
      shift_reg <= wr_data;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      unique case (ser_state_reg)
        pdsr_pkg::SER_ADDR: begin
          if (bit_cnt_reg == 3'h7) begin
            addr_reg <= wr_data[6:0];
            load_pend_reg <= ~shift_reg[6];
            ser_state_reg <= shift_reg[6] ? pdsr_pkg::SER_WDATA :
                             pdsr_pkg::SER_RDATA;
          end
        end
        pdsr_pkg::SER_WDATA,
        pdsr_pkg::SER_RDATA: begin
          if (bit_cnt_reg == 3'h7) begin
            ser_state_reg <= pdsr_pkg::SER_ADDR;
          end
        end
      endcase
    end else if (rd_load) begin
      load_pend_reg <= 1'b0;
    end
  end

  // Data pin: bit 7 at load, the rest after each falling edge
  always_ff @(posedge clk) begin
    if (!resetn || (ce && idle_out)) begin
      tx_reg <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else if (rd_load) begin
      tx_reg <= {rd_data[6:0], 1'b0};
      sdio_out <= rd_data[7];
      sdio_oe_n <= 1'b0;
    end else if (sclk_fall && ser_state_reg == pdsr_pkg::SER_RDATA &&
                 bit_cnt_reg != 3'h0) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      sdio_out <= tx_reg[7];
    end else if (sclk_rise && ser_state_reg == pdsr_pkg::SER_RDATA &&
                 bit_cnt_reg == 3'h7) begin
      sdio_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration and self test

  logic [7:0] cfg_reg;
  logic [TW-1:0] st_cnt_reg;
  logic wr_cfg;
  logic st_done;
  logic defaults_now;
  logic dump_en;

  assign wr_cfg = wr_now & (addr_reg == pdsr_pkg::REG_CONFIG);
  assign st_done = ce & self_test_busy &
                   (st_cnt_reg == TW'(SELF_TEST_CYCLES - 1));
  assign defaults_now = st_done |
                        (wr_cfg & wr_data[pdsr_pkg::CFG_RESET_BIT]);
  assign dump_en = cfg_reg[pdsr_pkg::CFG_PIXEL_DUMP_ENABLE_BIT];

  // Writes during the test are dropped unless they set the reset bit, the test ends in defaults
  always_ff @(posedge clk) begin
    if (!resetn || defaults_now) begin
      cfg_reg <= pdsr_pkg::CONFIG_RESET;
      self_test_busy <= 1'b0;
      st_cnt_reg <= '0;
    end else if (ce && self_test_busy) begin
      st_cnt_reg <= st_cnt_reg + TW'(1);
    end else if (wr_cfg && wr_data[pdsr_pkg::CFG_SELF_TEST_BIT]) begin
      self_test_busy <= 1'b1;
    end else if (wr_cfg) begin
      cfg_reg <= wr_data & pdsr_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_800 <= 1'b0;
    end else if (ce) begin
      res_800 <= cfg_reg[pdsr_pkg::CFG_RES_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame timing, sleep and LED

  logic [FW-1:0] frame_cnt_reg;
  logic [SW-1:0] sleep_cnt_reg;
  logic frame_tick;
  logic exposing;
  logic [15:0] expo_reg;

  assign frame_tick = ce & (frame_cnt_reg == FW'(FRAME_CYCLES - 1));
  assign exposing = 32'(frame_cnt_reg) < 32'(expo_reg);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_cnt_reg <= '0;
    end else if (ce) begin
      frame_cnt_reg <= frame_tick ? '0 : frame_cnt_reg + FW'(1);
    end
  end

  // Sleep timer restarts on motion; always-awake holds it at zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep_cnt_reg <= '0;
      asleep <= 1'b0;
      led_on <= 1'b0;
    end else if (ce) begin
      if (motion || cfg_reg[pdsr_pkg::CFG_SLEEP_BIT]) begin
        sleep_cnt_reg <= '0;
        asleep <= 1'b0;
      end else if (sleep_cnt_reg == SW'(SLEEP_CYCLES - 1)) begin
        asleep <= 1'b1;
      end else begin
        sleep_cnt_reg <= sleep_cnt_reg + SW'(1);
      end
      led_on <= ~asleep &
                (~cfg_reg[pdsr_pkg::CFG_LED_SHUTTER_BIT] | exposing);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Automatic gain control on the exposure value

  logic [15:0] expo_step;
  logic [16:0] expo_sum;
  logic [15:0] expo_up;
  logic [15:0] expo_agc;
  logic agc_up;
  logic agc_dn;

  // Brighten only when the whole image is not already bright
  assign agc_dn = frame_max_pixel > pdsr_pkg::AGC_MAX_HI;
  assign agc_up = (frame_max_pixel < pdsr_pkg::AGC_MAX_LO) &
                  (frame_avg_pixel < pdsr_pkg::AGC_AVG_HI);
  assign expo_step = expo_reg >> pdsr_pkg::EXPO_STEP_SHIFT;
  assign expo_sum = {1'b0, expo_reg} + {1'b0, expo_step};
  assign expo_up = (expo_sum > {1'b0, EXPO_MAX}) ? EXPO_MAX :
                   expo_sum[15:0];
  assign expo_agc = agc_dn ? expo_reg - expo_step :
                    agc_up ? expo_up : expo_reg;

  always_ff @(posedge clk) begin
    if (!resetn || defaults_now) begin
      expo_reg <= pdsr_pkg::EXPO_RESET;
    end else if (frame_tick) begin
      expo_reg <= expo_agc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel dump

  pdsr_pkg::pdsr_word_t result_reg;
  logic [7:0] dump_addr_reg;
  logic dump_en_d_reg;
  logic dump_start;
  logic dump_done;
  logic dump_adv;
  logic pop_req;
  logic fifo_valid;
  logic [pdsr_pkg::PIX_W-1:0] fifo_value;

  assign dump_start = ce & dump_en & ~dump_en_d_reg;
  assign dump_done = ~result_reg.lo[pdsr_pkg::FLAG_BIT] &
                     (dump_addr_reg == pdsr_pkg::PIX_ADDR_LAST);
  assign dump_adv = frame_tick & dump_en & ~dump_start &
                    ~result_reg.lo[pdsr_pkg::FLAG_BIT] & ~dump_done;
  assign pop_req = dump_en & (dump_start | (frame_tick & ~dump_done));

  // Samples queue here until the next frame takes one
  pdsr_fifo #(
    .WIDTH(pdsr_pkg::PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .flush(dump_start),
    .in_valid(pix_valid),
    .in_data(pix_value),
    .in_ready(pix_ready),
    .out_ready(pop_req),
    .out_valid(fifo_valid),
    .out_data(fifo_value)
  );

  // Controller ends the dump by clearing the enable bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dump_en_d_reg <= 1'b0;
    end else if (ce) begin
      dump_en_d_reg <= dump_en;
    end
  end

  // Result word: signature, or address with value and status flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_reg <= '0;
      dump_addr_reg <= pdsr_pkg::PIX_ADDR_FIRST;
    end else if (st_done) begin
      result_reg <= {pdsr_pkg::SIG_HI, pdsr_pkg::SIG_LO};
    end else if (dump_start) begin
      dump_addr_reg <= pdsr_pkg::PIX_ADDR_FIRST;
      result_reg <= {pdsr_pkg::PIX_ADDR_FIRST, pdsr_pkg::LO_INVALID};
    end else if (ce && fifo_valid && dump_en) begin
      result_reg <= {dump_addr_reg, 2'b00, fifo_value};
    end else if (dump_adv) begin
      dump_addr_reg <= dump_addr_reg + 8'h01;
      result_reg <= {dump_addr_reg + 8'h01, pdsr_pkg::LO_INVALID};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read side

  logic [7:0] res_lo_shadow_reg;
  logic [7:0] expo_lo_shadow_reg;
  logic res_pair_reg;
  logic expo_pair_reg;
  logic rd_res_hi;
  logic rd_expo_hi;

  assign rd_res_hi = addr_reg == pdsr_pkg::REG_RESULT_HI;
  assign rd_expo_hi = addr_reg == pdsr_pkg::REG_EXPO_HI;

  // A low byte read right after its high byte returns the same word
  assign rd_data =
    (addr_reg == pdsr_pkg::REG_CONFIG) ? cfg_reg :
    rd_res_hi ? result_reg.hi :
    (addr_reg == pdsr_pkg::REG_RESULT_LO) ?
      (res_pair_reg ? res_lo_shadow_reg : result_reg.lo) :
    rd_expo_hi ? expo_reg[15:8] :
    (addr_reg == pdsr_pkg::REG_EXPO_LO) ?
      (expo_pair_reg ? expo_lo_shadow_reg : expo_reg[7:0]) : 8'h00;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_lo_shadow_reg <= 8'h00;
      expo_lo_shadow_reg <= 8'h00;
      res_pair_reg <= 1'b0;
      expo_pair_reg <= 1'b0;
    end else if (rd_load) begin
      res_pair_reg <= rd_res_hi;
      expo_pair_reg <= rd_expo_hi;
      if (rd_res_hi) begin
        res_lo_shadow_reg <= result_reg.lo;
      end
      if (rd_expo_hi) begin
        expo_lo_shadow_reg <= expo_reg[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_ST_DEFAULTS: assert property (@(posedge clk) disable iff (!resetn)
    st_done |=> cfg_reg == pdsr_pkg::CONFIG_RESET &&
                expo_reg == pdsr_pkg::EXPO_RESET)
    else $error("Self test did not restore defaults");
  AST_ST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    self_test_busy && !st_done |=> $stable(cfg_reg))
    else $error("Configuration changed during self test");
  AST_RES_PAIR: assert property (@(posedge clk) disable iff (!resetn)
    rd_load && rd_res_hi |=> res_pair_reg &&
      res_lo_shadow_reg == $past(result_reg.lo))
    else $error("Low result byte not held after high read");
  AST_SIG: assert property (@(posedge clk) disable iff (!resetn)
    st_done |=> result_reg.hi == pdsr_pkg::SIG_HI &&
                result_reg.lo == pdsr_pkg::SIG_LO)
    else $error("Self test signature missing");
  AST_DUMP_FIRST: assert property (@(posedge clk) disable iff (!resetn)
    dump_start && !st_done |=> result_reg.hi == pdsr_pkg::PIX_ADDR_FIRST &&
      result_reg.lo[pdsr_pkg::FLAG_BIT])
    else $error("Dump did not start at the first pixel");
  AST_VALID_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    ce && fifo_valid && dump_en && !st_done && !dump_start |=>
      !result_reg.lo[pdsr_pkg::FLAG_BIT] &&
      result_reg.hi == $past(dump_addr_reg))
    else $error("Loaded pixel not flagged valid");
  AST_ADVANCE: assert property (@(posedge clk) disable iff (!resetn)
    dump_adv && !st_done && !fifo_valid |=>
      dump_addr_reg == $past(dump_addr_reg) + 8'h01 &&
      result_reg.lo[pdsr_pkg::FLAG_BIT])
    else $error("Pixel address did not advance");
  AST_EXPO_STEP: assert property (@(posedge clk) disable iff (!resetn)
    frame_tick && !defaults_now |=>
      expo_reg <= $past(expo_reg) + ($past(expo_reg) >> 4) &&
      expo_reg >= $past(expo_reg) - ($past(expo_reg) >> 4))
    else $error("Exposure stepped more than a sixteenth");
  AST_EXPO_MAX: assert property (@(posedge clk) disable iff (!resetn)
    frame_tick |=> expo_reg <= EXPO_MAX)
    else $error("Exposure above its ceiling");
  AST_CFG_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    wr_cfg && !self_test_busy |=> !cfg_reg[pdsr_pkg::CFG_SELF_TEST_BIT] &&
      !cfg_reg[pdsr_pkg::CFG_RESET_BIT])
    else $error("Self test or reset bit stored");
  AST_AWAKE: assert property (@(posedge clk) disable iff (!resetn)
    ce && cfg_reg[pdsr_pkg::CFG_SLEEP_BIT] |=> !asleep)
    else $error("Sensor slept while always awake");
endmodule

// ---- verilog/pdsr_pkg.sv ----
package pdsr_pkg;
  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = 100;
  localparam int FRAME_RATE = 1500;
  localparam int SHUTTER_OVERHEAD = 2816;
  localparam int SELF_TEST_US = 200;
  localparam int SLEEP_S = 1;
  localparam int IDLE_TIMEOUT_NS = 20000;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS * CLK_MHZ / 1000;

  // Register offsets, bit 7 of the address byte selects a write
  localparam logic [6:0] REG_CONFIG = 7'h0a;
  localparam logic [6:0] REG_RESERVED_B = 7'h0b;
  localparam logic [6:0] REG_RESULT_LO = 7'h0c;
  localparam logic [6:0] REG_RESULT_HI = 7'h0d;
  localparam logic [6:0] REG_EXPO_LO = 7'h0e;
  localparam logic [6:0] REG_EXPO_HI = 7'h0f;

  // Configuration field positions and values
  localparam int CFG_RESET_BIT = 7;
  localparam int CFG_LED_SHUTTER_BIT = 6;
  localparam int CFG_SELF_TEST_BIT = 5;
  localparam int CFG_RES_BIT = 4;
  localparam int CFG_PIXEL_DUMP_ENABLE_BIT = 3;
  localparam int CFG_SLEEP_BIT = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CFG_WR_MASK = 8'h59;

  // Result word contents
  localparam logic [7:0] SIG_HI = 8'h8a;
  localparam logic [7:0] SIG_LO = 8'hf3;
  localparam logic [7:0] LO_INVALID = 8'h80;
  localparam int FLAG_BIT = 7;
  localparam logic [7:0] PIX_ADDR_FIRST = 8'h00;
  localparam logic [7:0] PIX_ADDR_LAST = 8'hff;
  localparam int PIX_W = 6;

  // Exposure control
  localparam logic [15:0] EXPO_RESET = 16'h0040;
  localparam int EXPO_STEP_SHIFT = 4;
  localparam logic [5:0] AGC_MAX_LO = 6'h35;
  localparam logic [5:0] AGC_MAX_HI = 6'h39;
  localparam logic [5:0] AGC_AVG_HI = 6'h30;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } pdsr_word_t;

  typedef enum logic [1:0] {SER_ADDR, SER_WDATA, SER_RDATA} pdsr_ser_t;
endpackage

// ---- verilog/pdsr_fifo.sv ----
`timescale 1ns/1ps
module pdsr_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 32
) (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side, data arrive one cycle after the request
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pdsr_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  // Ready is registered, so a push never lands on a full memory
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_ready & (count_reg != '0) & ~flush;
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Storage has no reset, only the pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!resetn || (ce && flush)) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      in_ready <= count_next != (AW+1)'(DEPTH);
    end
  end

  // Read data leave through a register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      out_valid <= pop;
      if (pop) begin
        out_data <= mem[rd_ptr_reg];
      end
    end
  end
endmodule

// ---- dv/pdsr_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Controller on the far side of the two-wire port
module pdsr_host (
  // Serial port
  output logic sclk,
  output logic sdo,
  input wire logic sdio
);
  // Clock idles high, so it stands still between frames
  initial begin
    sclk = 1'b1;
    sdo = 1'b1;
  end

  // Address byte then data byte, MSB first, 125 ns serial period
  task automatic xfer(input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdo = a[i];
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      // Released on reads: toggling keeps a stale level from passing
      sdo = a[7] ? wd[i] : ~sdo;
      #62.5;
      rd[i] = sdio;
      sclk = 1'b1;
      #62.5;
    end
    #100;
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
////////////////////////////////////////////////////////////////////////
module tb;
  localparam int FRAME = 2900;
  localparam logic [15:0] LIMIT =
    16'(FRAME - pdsr_pkg::SHUTTER_OVERHEAD);
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic motion = 1'b0;
  logic pix_valid = 1'b0;
  logic [5:0] pix_value = 6'h00;
  logic [5:0] fmax = 6'h37;
  logic [5:0] favg = 6'h20;
  logic host_sclk, host_d, sdio_w, sdio_out, sdio_oe_n, pix_ready;
  logic asleep, led_on, res_800, busy;
  logic [7:0] h, l;
  logic [15:0] p, c, e;
  int n_mismatch = 0;
  int checked = 0;

  always #5 clk = ~clk;
  // Pin level: the sensor wins while its enable is low
  assign sdio_w = sdio_oe_n ? host_d : sdio_out;

  pdsr_readout #(.FRAME_CYCLES(FRAME), .SELF_TEST_CYCLES(50),
    .SLEEP_CYCLES(200)) i_dut (.clk(clk), .resetn(resetn), .ce(1'b1),
    .sclk(host_sclk), .sdio_in(sdio_w), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .pix_valid(pix_valid), .pix_value(pix_value),
    .pix_ready(pix_ready), .frame_max_pixel(fmax),
    .frame_avg_pixel(favg), .motion(motion), .asleep(asleep),
    .led_on(led_on), .res_800(res_800), .self_test_busy(busy));
  pdsr_host i_host (.sclk(host_sclk), .sdo(host_d), .sdio(sdio_w));

  // Array stand-in: counts per accepted sample, so value = address mod 64
  always @(posedge clk) begin
    if (pix_valid && pix_ready) begin
      pix_value <= #1 pix_value + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    i_host.xfer({1'b0, a}, 8'h00, d);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.xfer({1'b1, a}, d, x);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] ex);
    logic [7:0] d;
    rd(a, d);
    `CHK("register", ex, d)
  endtask
  task automatic expo(output logic [15:0] v);
    rd(7'h0f, v[15:8]);
    rd(7'h0e, v[7:0]);
  endtask
  // Samples closer than a frame apart: each step is zero or one AUTOMATIC_GAIN_CONTROL step
  task automatic automatic_gain_control(input bit up, input int n);
    expo(p);
    repeat (n) begin
      clks(1000);
      expo(c);
      e = up ? p + (p >> 4) : p - (p >> 4);
      if (up && e > LIMIT) e = LIMIT;
      if (c !== p) `CHK("exposure step", e, c)
      p = c;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bit got;
    logic [11:0] n;
    clks(3);
    resetn = 1'b1;
    clks(250);
    `CHK("asleep", 1'b1, asleep)
    `CHK("led_on", 1'b0, led_on)
    motion = 1'b1;
    clks(1);
    motion = 1'b0;
    clks(3);
    `CHK("asleep", 1'b0, asleep)
    `CHK("led_on", 1'b1, led_on)
    rdc(7'h0f, 8'h00);
    rdc(7'h0e, 8'h40);
    rdc(7'h0b, 8'h00);
    wr(7'h0f, 8'h55);
    rdc(7'h0f, 8'h00);
    wr(7'h0a, 8'h11);
    rdc(7'h0a, 8'h11);
    `CHK("res_800", 1'b1, res_800)
    wr(7'h0a, 8'h80);
    rdc(7'h0a, 8'h00);
    `CHK("res_800", 1'b0, res_800)
    // Shutter-gated LED: lit for exactly the exposure, 64 cycles a frame
    wr(7'h0a, 8'h41);
    rdc(7'h0a, 8'h41);
    n = 12'h000;
    repeat (FRAME) begin
      clks(1);
      n = n + {11'h000, led_on};
    end
    `CHK("led on time", 12'h040, n)
    wr(7'h0a, 8'h20);
    `CHK("busy", 1'b1, busy)
    for (int t = 0; t < 200 && busy !== 1'b0; t++) clks(1);
    if (busy !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
    rdc(7'h0a, 8'h00);
    `CHK("res_800", 1'b0, res_800)
    rdc(7'h0d, pdsr_pkg::SIG_HI);
    rdc(7'h0d, pdsr_pkg::SIG_HI);
    rdc(7'h0c, pdsr_pkg::SIG_LO);
    wr(7'h0a, 8'h09);
    clks(1);
    pix_valid = 1'b1;
    clks(60);
    `CHK("fifo full", 1'b0, pix_ready)
    for (int k = 0; k < 4; k++) begin
      got = 1'b0;
      for (int t = 0; t < 40 && !got; t++) begin
        rd(7'h0d, h);
        rd(7'h0c, l);
        got = (l[7] === 1'b0 && h === 8'(k));
      end
      if (!got) begin
        n_mismatch++;
        print_verdict();
      end
      `CHK("pixel", {2'b00, 6'(k)}, l)
    end
    wr(7'h0a, 8'h01);
    clks(1);
    pix_valid = 1'b0;
    rdc(7'h0a, 8'h01);
    clks(1);
    fmax = 6'h10;
    favg = 6'h10;
    automatic_gain_control(1'b1, 18);
    `CHK("exposure cap", LIMIT, p)
    clks(1);
    fmax = 6'h3f;
    automatic_gain_control(1'b0, 4);
    `CHK("exposure falls", 1'b1, p < LIMIT)
    print_verdict();
  end
endmodule
